// ### verilog/crs_pkg.sv
// Purpose: constants for the cpu register and stack state block
// Assumes: AXI4-Lite slave, 32-bit data, 8-bit byte address
// Notes: flag layout is c z n i h from bit 0 upward
package crs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int PTR_W = 13;
	localparam int IDX_W = 6;
	localparam int FLAG_W = 5;
	localparam int STACK_DEPTH = 64;
	localparam int LEN_W = 3;

	// register byte addresses
	localparam logic [7:0] ADR_SUM = 8'h00;
	localparam logic [7:0] ADR_OFFSET = 8'h04;
	localparam logic [7:0] ADR_FETCH = 8'h08;
	localparam logic [7:0] ADR_PUSH = 8'h0C;
	localparam logic [7:0] ADR_FLAG = 8'h10;
	localparam logic [7:0] ADR_CMD = 8'h14;
	localparam logic [7:0] ADR_PULLED = 8'h18;
	localparam logic [7:0] ADR_EA = 8'h1C;
	localparam logic [7:0] ADR_PROBE = 8'h20;
	localparam logic [7:0] ADR_PEND = 8'h24;

	// flag bit positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_I = 3;
	localparam int FLG_H = 4;

	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OPND_LSB = 8;
	localparam int CMD_TGT_LSB = 16;

	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_PUSH = 4'h1;
	localparam logic [3:0] OP_PULL = 4'h2;
	localparam logic [3:0] OP_CALL = 4'h3;
	localparam logic [3:0] OP_RTS = 4'h4;
	localparam logic [3:0] OP_SWI = 4'h5;
	localparam logic [3:0] OP_RTI = 4'h6;
	localparam logic [3:0] OP_RSP = 4'h7;
	localparam logic [3:0] OP_ADD = 4'h8;
	localparam logic [3:0] OP_ADC = 4'h9;
	localparam logic [3:0] OP_SUB = 4'hA;
	localparam logic [3:0] OP_AND = 4'hB;
	localparam logic [3:0] OP_LSL = 4'hC;
	localparam logic [3:0] OP_ROL = 4'hD;
	localparam logic [3:0] OP_BTST = 4'hE;
	localparam logic [3:0] OP_IRQ = 4'hF;

	localparam logic [2:0] LEN_ONE = 3'h1;
	localparam logic [2:0] LEN_CALL = 3'h2;
	localparam logic [2:0] LEN_INT = 3'h5;

	// stack window and vectors
	localparam logic [6:0] STACK_PREFIX = 7'h01;
	localparam logic [5:0] STACK_TOP_IDX = 6'h3F;
	localparam logic [12:0] VEC_RESET = 13'h1FFE;
	localparam logic [12:0] VEC_SWI = 13'h1FFC;
	localparam logic [12:0] VEC_EXT = 13'h1FFA;
	localparam logic [12:0] VEC_TMR = 13'h1FF8;
	localparam logic [12:0] VEC_FIRST = 13'h1FF6;
	localparam logic [12:0] LOW_IO_END = 13'h000F;
	localparam logic [12:0] LOW_RAM_END = 13'h007F;

	localparam logic [1:0] REG_IO = 2'h0;
	localparam logic [1:0] REG_RAM = 2'h1;
	localparam logic [1:0] REG_VEC = 2'h2;
	localparam logic [1:0] REG_ROM = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {ST_IDLE, ST_PUSH, ST_PULL} crs_state_t;
endpackage : crs_pkg

// ### verilog/crs_core.sv
// Purpose: programmer-visible cpu state with a wrapping 64-byte stack
// Assumes: one clock, software drives operations through a command word
// Notes: sum, offset, fetch and most flags keep their value over reset
`timescale 1ns/1ps
// Summary of operation
// - eight-bit sum register holds operands and results of arithmetic
// - eight-bit offset register forms indexed effective address, also temp
// - thirteen-bit fetch pointer holds address of next instruction
// - stack addresses carry fixed upper pattern 0000001 plus six index bits
// - every stack address lies between 007F and 0040
// - either reset or reset-stack command loads push pointer with 007F
// - push decrements push pointer, pull increments it
// - beyond 64 bytes the pointer wraps to its top silently
// - call pushes two bytes, interrupt pushes five bytes
// - fetch low byte pushed first, then high, then rest; pull reverses
// - five-bit flag register shows outcome, each flag readable alone
// - add and add-with-carry set half carry from bit 3 into 4
// - hold-off flag blocks pin and timer interrupts, clearing enables them
// - requests arriving while held off are latched and served later
// - sign flag copies bit 7 of the last result
// - zero flag set when last result is zero, cleared otherwise
// - carry on carry or borrow, also by bit test, shift, rotate
// - two reset sources: active-low pin and power-on reset
// - address space of 8192 bytes is decoded
// - ports, timer and 112 RAM bytes fill lowest 128 addresses
// - ten highest addresses hold reset and interrupt vectors
// - either reset sets the hold-off flag
// - reset drives the address bus to the reset vector
module crs_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic reset_pin_n,
	input wire logic irq_pin_n,
	input wire logic timer_req,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [12:0] bus_addr,
	output logic core_in_reset
);
	logic [7:0] sum_reg;
	logic [7:0] offset_reg;
	logic [12:0] fetch_ptr;
	logic [5:0] push_idx_reg;
	logic [4:0] flag_reg;
	logic [7:0] stack_mem [0:crs_pkg::STACK_DEPTH-1];
	logic [7:0] pulled_reg;
	logic [7:0] opnd_reg;
	logic [12:0] target_reg;
	logic [12:0] probe_reg;
	logic [12:0] vec_sel_reg;
	logic ext_pend_reg;
	logic tmr_pend_reg;
	logic rst_s1_reg, rst_s2_reg, rst_s3_reg, rst_lvl_reg;
	logic irq_s1_reg, irq_s2_reg, irq_s3_reg, irq_lvl_reg;
	crs_pkg::crs_state_t state_reg;
	logic [3:0] kind_reg;
	logic [2:0] len_reg;
	logic [2:0] cnt_reg;
	logic aw_have_reg, w_have_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;

	logic rst;
	logic irq_fall;
	logic do_write;
	logic [7:0] wa;
	logic [31:0] wword;
	logic wr_sum, wr_off, wr_fetch, wr_push, wr_flag, wr_cmd, wr_probe;
	logic wr_hit;
	logic [3:0] cmd_op;
	logic idle;
	logic irq_go, cmd_go, seq_start;
	logic [3:0] start_kind;
	logic [2:0] start_len;
	logic start_push;
	logic push_act, pull_act, seq_last;
	logic [5:0] pull_idx;
	logic [7:0] pull_byte;
	logic [7:0] push_byte;
	logic [8:0] alu_res;
	logic [4:0] alu_half;
	logic alu_wr, alu_flags;
	logic [31:0] rd_word;
	logic rd_err;
	logic [1:0] probe_region;

	function automatic logic [31:0] crs_merge(input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < crs_pkg::STRB_W; b++) begin
			if (st[b]) begin
				m[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return m;
	endfunction : crs_merge

	// reset pin: three flops, level taken when the last two agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= 1'b1;
			rst_s3_reg <= 1'b1;
			rst_lvl_reg <= 1'b1;
		end else begin
			rst_s1_reg <= reset_pin_n;
			rst_s2_reg <= rst_s1_reg;
			rst_s3_reg <= rst_s2_reg;
			if (rst_s2_reg == rst_s3_reg) begin
				rst_lvl_reg <= rst_s3_reg;
			end
		end
	end

	// power-on or stable low pin both count as reset
	assign rst = !aresetn || !rst_lvl_reg;
	assign core_in_reset = rst;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_s1_reg <= 1'b1;
			irq_s2_reg <= 1'b1;
			irq_s3_reg <= 1'b1;
			irq_lvl_reg <= 1'b1;
		end else begin
			irq_s1_reg <= irq_pin_n;
			irq_s2_reg <= irq_s1_reg;
			irq_s3_reg <= irq_s2_reg;
			if (irq_s2_reg == irq_s3_reg) begin
				irq_lvl_reg <= irq_s3_reg;
			end
		end
	end

	// falling edge only; a held-low line is seen once per edge
	assign irq_fall = irq_lvl_reg && (irq_s2_reg == irq_s3_reg) && !irq_s3_reg;

	// write channel capture, address and data in either order
	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= crs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? crs_pkg::RESP_OKAY
					: crs_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign wa = {aw_addr_reg[7:2], 2'b00};
	assign wword = crs_merge(w_data_reg, w_strb_reg);
	assign wr_sum = do_write && (wa == crs_pkg::ADR_SUM);
	assign wr_off = do_write && (wa == crs_pkg::ADR_OFFSET);
	assign wr_fetch = do_write && (wa == crs_pkg::ADR_FETCH);
	assign wr_push = do_write && (wa == crs_pkg::ADR_PUSH);
	assign wr_flag = do_write && (wa == crs_pkg::ADR_FLAG);
	assign wr_cmd = do_write && (wa == crs_pkg::ADR_CMD);
	assign wr_probe = do_write && (wa == crs_pkg::ADR_PROBE);
	assign wr_hit = wr_sum || wr_off || wr_fetch || wr_push || wr_flag
		|| wr_cmd || wr_probe;
	assign cmd_op = wword[crs_pkg::CMD_OP_LSB +: 4];

	// sequence start: pending interrupt outranks a software command
	assign idle = (state_reg == crs_pkg::ST_IDLE);
	assign irq_go = idle && !rst && !flag_reg[crs_pkg::FLG_I]
		&& (ext_pend_reg || tmr_pend_reg);
	assign cmd_go = wr_cmd && idle && !irq_go && !rst;

	always_comb begin
		start_kind = crs_pkg::OP_NOP;
		start_len = crs_pkg::LEN_ONE;
		start_push = 1'b1;
		seq_start = 1'b0;
		if (irq_go) begin
			start_kind = crs_pkg::OP_IRQ;
			start_len = crs_pkg::LEN_INT;
			seq_start = 1'b1;
		end else if (cmd_go) begin
			start_kind = cmd_op;
			case (cmd_op)
				crs_pkg::OP_PUSH: begin
					seq_start = 1'b1;
				end
				crs_pkg::OP_PULL: begin
					start_push = 1'b0;
					seq_start = 1'b1;
				end
				crs_pkg::OP_CALL: begin
					start_len = crs_pkg::LEN_CALL;
					seq_start = 1'b1;
				end
				crs_pkg::OP_RTS: begin
					start_len = crs_pkg::LEN_CALL;
					start_push = 1'b0;
					seq_start = 1'b1;
				end
				crs_pkg::OP_SWI: begin
					start_len = crs_pkg::LEN_INT;
					seq_start = 1'b1;
				end
				crs_pkg::OP_RTI: begin
					start_len = crs_pkg::LEN_INT;
					start_push = 1'b0;
					seq_start = 1'b1;
				end
				default: begin
					seq_start = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			state_reg <= crs_pkg::ST_IDLE;
			kind_reg <= crs_pkg::OP_NOP;
			len_reg <= crs_pkg::LEN_ONE;
			cnt_reg <= 3'h0;
		end else begin
			case (state_reg)
				crs_pkg::ST_IDLE: begin
					cnt_reg <= 3'h0;
					if (seq_start) begin
						kind_reg <= start_kind;
						len_reg <= start_len;
						state_reg <= start_push ? crs_pkg::ST_PUSH
							: crs_pkg::ST_PULL;
					end
				end
				crs_pkg::ST_PUSH, crs_pkg::ST_PULL: begin
					cnt_reg <= cnt_reg + 3'h1;
					if (seq_last) begin
						state_reg <= crs_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= crs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign push_act = (state_reg == crs_pkg::ST_PUSH);
	assign pull_act = (state_reg == crs_pkg::ST_PULL);
	assign seq_last = (cnt_reg == len_reg - crs_pkg::LEN_ONE);
	// six-bit index wraps inside the window, old bytes are overwritten
	assign pull_idx = push_idx_reg + 6'h01;
	assign pull_byte = stack_mem[pull_idx];

	// low fetch byte first, then high, then offset, sum, flags
	always_comb begin
		push_byte = opnd_reg;
		if (kind_reg != crs_pkg::OP_PUSH) begin
			case (cnt_reg)
				3'h0: push_byte = fetch_ptr[7:0];
				3'h1: push_byte = {3'b000, fetch_ptr[12:8]};
				3'h2: push_byte = offset_reg;
				3'h3: push_byte = sum_reg;
				default: push_byte = {3'b111, flag_reg};
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (push_act) begin
			stack_mem[push_idx_reg] <= push_byte;
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			push_idx_reg <= crs_pkg::STACK_TOP_IDX;
		end else if (push_act) begin
			push_idx_reg <= push_idx_reg - 6'h01;
		end else if (pull_act) begin
			push_idx_reg <= pull_idx;
		end else if (cmd_go && cmd_op == crs_pkg::OP_RSP) begin
			push_idx_reg <= crs_pkg::STACK_TOP_IDX;
		end else if (wr_push) begin
			push_idx_reg <= wword[5:0];
		end
	end

	// pulls in reverse order: flags, sum, offset, high, low
	always_ff @(posedge aclk) begin
		if (rst) begin
			pulled_reg <= 8'h00;
		end else if (pull_act) begin
			pulled_reg <= pull_byte;
		end
	end

	always_comb begin
		alu_res = {1'b0, sum_reg};
		alu_half = 5'h00;
		alu_wr = 1'b1;
		alu_flags = 1'b1;
		case (cmd_op)
			crs_pkg::OP_ADD: begin
				alu_res = {1'b0, sum_reg} + {1'b0, wword[15:8]};
				alu_half = {1'b0, sum_reg[3:0]} + {1'b0, wword[11:8]};
			end
			crs_pkg::OP_ADC: begin
				alu_res = {1'b0, sum_reg} + {1'b0, wword[15:8]}
					+ {8'h00, flag_reg[crs_pkg::FLG_C]};
				alu_half = {1'b0, sum_reg[3:0]} + {1'b0, wword[11:8]}
					+ {4'h0, flag_reg[crs_pkg::FLG_C]};
			end
			crs_pkg::OP_SUB: alu_res = {1'b0, sum_reg} - {1'b0, wword[15:8]};
			crs_pkg::OP_AND: begin
				alu_res = {flag_reg[crs_pkg::FLG_C], sum_reg & wword[15:8]};
			end
			crs_pkg::OP_LSL: alu_res = {sum_reg, 1'b0};
			crs_pkg::OP_ROL: alu_res = {sum_reg, flag_reg[crs_pkg::FLG_C]};
			crs_pkg::OP_BTST: begin
				alu_res = {sum_reg[wword[10:8]], sum_reg};
				alu_wr = 1'b0;
				alu_flags = 1'b0;
			end
			default: begin
				alu_wr = 1'b0;
				alu_flags = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (pull_act && kind_reg == crs_pkg::OP_RTI && cnt_reg == 3'h1) begin
			sum_reg <= pull_byte;
		end else if (cmd_go && alu_wr) begin
			sum_reg <= alu_res[7:0];
		end else if (wr_sum) begin
			sum_reg <= wword[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (pull_act && kind_reg == crs_pkg::OP_RTI && cnt_reg == 3'h2) begin
			offset_reg <= pull_byte;
		end else if (wr_off) begin
			offset_reg <= wword[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (push_act && seq_last && kind_reg == crs_pkg::OP_CALL) begin
			fetch_ptr <= target_reg;
		end else if (pull_act && ((kind_reg == crs_pkg::OP_RTS
			&& cnt_reg == 3'h0) || (kind_reg == crs_pkg::OP_RTI
			&& cnt_reg == 3'h3))) begin
			fetch_ptr[12:8] <= pull_byte[4:0];
		end else if (pull_act && seq_last && kind_reg != crs_pkg::OP_PULL) begin
			fetch_ptr[7:0] <= pull_byte;
		end else if (wr_fetch) begin
			fetch_ptr <= wword[12:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (rst) begin
			flag_reg[crs_pkg::FLG_I] <= 1'b1;
		end else if (pull_act && kind_reg == crs_pkg::OP_RTI
			&& cnt_reg == 3'h0) begin
			flag_reg <= pull_byte[4:0];
		end else if (push_act && seq_last && (kind_reg == crs_pkg::OP_IRQ
			|| kind_reg == crs_pkg::OP_SWI)) begin
			flag_reg[crs_pkg::FLG_I] <= 1'b1;
		end else if (cmd_go && (alu_flags || cmd_op == crs_pkg::OP_BTST)) begin
			flag_reg[crs_pkg::FLG_C] <= alu_res[8];
			if (alu_flags) begin
				flag_reg[crs_pkg::FLG_N] <= alu_res[7];
				flag_reg[crs_pkg::FLG_Z] <= (alu_res[7:0] == 8'h00);
			end
			if (cmd_op == crs_pkg::OP_ADD || cmd_op == crs_pkg::OP_ADC) begin
				flag_reg[crs_pkg::FLG_H] <= alu_half[4];
			end
		end else if (wr_flag) begin
			flag_reg <= wword[4:0];
		end
	end

	// latched requests; a new event in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (rst) begin
			ext_pend_reg <= 1'b0;
			tmr_pend_reg <= 1'b0;
			vec_sel_reg <= crs_pkg::VEC_RESET;
			opnd_reg <= 8'h00;
			target_reg <= 13'h0000;
		end else begin
			if (irq_fall) begin
				ext_pend_reg <= 1'b1;
			end else if (irq_go && ext_pend_reg) begin
				ext_pend_reg <= 1'b0;
			end
			if (timer_req) begin
				tmr_pend_reg <= 1'b1;
			end else if (irq_go && !ext_pend_reg) begin
				tmr_pend_reg <= 1'b0;
			end
			if (irq_go) begin
				vec_sel_reg <= ext_pend_reg ? crs_pkg::VEC_EXT
					: crs_pkg::VEC_TMR;
			end else if (cmd_go && cmd_op == crs_pkg::OP_SWI) begin
				vec_sel_reg <= crs_pkg::VEC_SWI;
			end
			if (cmd_go) begin
				opnd_reg <= wword[crs_pkg::CMD_OPND_LSB +: 8];
				target_reg <= wword[crs_pkg::CMD_TGT_LSB +: crs_pkg::PTR_W];
			end
		end
	end

	// bus shows the stack slot while stacking, else the last vector
	always_ff @(posedge aclk) begin
		if (rst) begin
			bus_addr <= crs_pkg::VEC_RESET;
		end else if (push_act) begin
			bus_addr <= {crs_pkg::STACK_PREFIX, push_idx_reg};
		end else if (pull_act) begin
			bus_addr <= {crs_pkg::STACK_PREFIX, pull_idx};
		end else begin
			bus_addr <= vec_sel_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			probe_reg <= 13'h0000;
		end else if (wr_probe) begin
			probe_reg <= wword[12:0];
		end
	end

	always_comb begin
		if (probe_reg <= crs_pkg::LOW_IO_END) begin
			probe_region = crs_pkg::REG_IO;
		end else if (probe_reg <= crs_pkg::LOW_RAM_END) begin
			probe_region = crs_pkg::REG_RAM;
		end else if (probe_reg >= crs_pkg::VEC_FIRST) begin
			probe_region = crs_pkg::REG_VEC;
		end else begin
			probe_region = crs_pkg::REG_ROM;
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err = 1'b0;
		case ({s_axi_araddr[7:2], 2'b00})
			crs_pkg::ADR_SUM: rd_word[7:0] = sum_reg;
			crs_pkg::ADR_OFFSET: rd_word[7:0] = offset_reg;
			crs_pkg::ADR_FETCH: rd_word[12:0] = fetch_ptr;
			crs_pkg::ADR_PUSH: rd_word[12:0] = {crs_pkg::STACK_PREFIX,
				push_idx_reg};
			crs_pkg::ADR_FLAG: rd_word[4:0] = flag_reg;
			crs_pkg::ADR_CMD: rd_word[0] = !idle;
			crs_pkg::ADR_PULLED: rd_word[7:0] = pulled_reg;
			crs_pkg::ADR_EA: rd_word[8:0] = {1'b0, offset_reg}
				+ {1'b0, opnd_reg};
			crs_pkg::ADR_PROBE: rd_word[14:0] = {probe_region, probe_reg};
			crs_pkg::ADR_PEND: rd_word[2:0] = {rst_lvl_reg, tmr_pend_reg,
				ext_pend_reg};
			default: rd_err = 1'b1;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= crs_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_err ? crs_pkg::RESP_SLVERR : crs_pkg::RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : crs_core

// ### bench/crs_asserts.sv
// Purpose: port checker for crs_core
// Assumes: one clock, aresetn synchronous active low
// Notes: stack and vector addresses judged on bus_addr only
`timescale 1ns/1ps
module crs_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic reset_pin_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [12:0] bus_addr,
	input wire logic core_in_reset
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_aw;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence s_w;
		s_axi_wvalid && s_axi_wready;
	endsequence
	property p_wr_resp;
		s_aw and s_w |=> ##1 s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read response late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("arready with rvalid");
	property p_win;
		bus_addr inside {[13'h0040:13'h007F], [13'h1FF6:13'h1FFF]};
	endproperty
	a_win: assert property (p_win) else $error("address off window");
	property p_pin_rst;
		!reset_pin_n [*6] |-> core_in_reset;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed");
	property p_pin_rel;
		reset_pin_n [*6] |-> !core_in_reset;
	endproperty
	a_pin_rel: assert property (p_pin_rel) else $error("reset stuck");
	property p_vec;
		core_in_reset |=> bus_addr == 13'h1FFE;
	endproperty
	a_vec: assert property (p_vec) else $error("no reset vector");
endmodule : crs_asserts
bind crs_core crs_asserts u_chk (.*);

// ### bench/crs_src.sv
// Purpose: far-side sources of interrupt, timer and reset pin
// Assumes: pulses on the go inputs come one cycle long
// Notes: interrupt pin has a pull-up, so idle reads high
`timescale 1ns/1ps
module crs_src (
	input wire logic aclk,
	input wire logic ext_go,
	input wire logic tmr_go,
	input wire logic rst_go,
	output logic irq_pin_n,
	output logic timer_req,
	output logic reset_pin_n
);
	logic [2:0] irq_cnt = 3'h0;
	logic [2:0] rst_cnt = 3'h0;
	always @(posedge aclk) begin
		irq_cnt <= ext_go ? 3'h3 : irq_cnt - (irq_cnt != 3'h0);
		rst_cnt <= rst_go ? 3'h7 : rst_cnt - (rst_cnt != 3'h0);
		timer_req <= tmr_go;
	end
	assign irq_pin_n = irq_cnt == 3'h0;
	// held low seven cycles, well over one cycle
	assign reset_pin_n = rst_cnt == 3'h0;
endmodule : crs_src

// ### bench/tb_cpu_register_stack_state.sv
// Purpose: self-checking bench for crs_core
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes: ready and valid sampled at the falling edge before the take
`timescale 1ns/1ps
module tb_cpu_register_stack_state;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ext_go = 1'b0;
	logic tmr_go = 1'b0;
	logic rst_go = 1'b0;
	logic irq_pin_n, timer_req, reset_pin_n, core_in_reset;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	logic [12:0] bus_addr;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	// op, operand a, operand b, result, flags
	localparam logic [35:0] ALU_TAB [8] = '{36'h8_0F_01_10_10,
		36'h9_0F_01_10_10, 36'h8_80_80_00_03, 36'hA_00_01_FF_05,
		36'hB_F0_0F_00_02, 36'hC_81_00_02_01, 36'hD_80_00_00_03,
		36'hE_08_03_08_03};
	always #50 aclk = ~aclk;
	crs_core dut (.*);
	crs_src src (.aclk, .ext_go, .tmr_go, .rst_go, .irq_pin_n, .timer_req,
		.reset_pin_n);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic da, dw, ha, hw, hb;
		da = 0;
		dw = 0;
		hb = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			da = da | ha;
			dw = dw | hw;
		end
		while (!hb) begin
			@(negedge aclk);
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
		end
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		logic h;
		h = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!h) begin
			@(negedge aclk);
			h = s_axi_arready;
			@(posedge aclk);
		end
		s_axi_arvalid <= 1'b0;
		h = 0;
		while (!h) begin
			@(negedge aclk);
			h = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end
		s_axi_rready <= 1'b0;
	endtask : rd
	task rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp);
	endtask : rc
	task idle;
		int n;
		n = 0;
		do begin
			rd(crs_pkg::ADR_CMD);
			n++;
		end while (d[0] !== 1'b0 && n < 20);
		chk(d & 32'h1, 32'h0);
	endtask : idle
	task cmd(input logic [3:0] op, input logic [7:0] x, input logic [12:0] t);
		wr(crs_pkg::ADR_CMD, {3'h0, t, x, 4'h0, op});
		idle();
	endtask : cmd
	task t_regs;
		wr(crs_pkg::ADR_SUM, 32'hA5);
		wr(crs_pkg::ADR_OFFSET, 32'h3C);
		wr(crs_pkg::ADR_FETCH, 32'h1ABC);
		wr(crs_pkg::ADR_FLAG, 32'hFF);
		rc(crs_pkg::ADR_SUM, 32'hA5);
		rc(crs_pkg::ADR_OFFSET, 32'h3C);
		rc(crs_pkg::ADR_FETCH, 32'h1ABC);
		rc(crs_pkg::ADR_FLAG, 32'h1F);
		cmd(crs_pkg::OP_NOP, 8'hF0, 13'h0);
		rc(crs_pkg::ADR_EA, 32'h12C);
		wr(crs_pkg::ADR_PROBE, 32'h7F);
		rc(crs_pkg::ADR_PROBE, 32'h207F);
		wr(crs_pkg::ADR_PROBE, 32'h1FF6);
		rc(crs_pkg::ADR_PROBE, 32'h5FF6);
		rc(8'h40, 32'h0);
		chk({30'h0, r}, {30'h0, crs_pkg::RESP_SLVERR});
		wr(8'h44, 32'h1);
		chk({30'h0, r}, {30'h0, crs_pkg::RESP_SLVERR});
	endtask : t_regs
	task t_alu;
		logic [35:0] e;
		foreach (ALU_TAB[i]) begin
			e = ALU_TAB[i];
			wr(crs_pkg::ADR_SUM, {24'h0, e[31:24]});
			wr(crs_pkg::ADR_FLAG, 32'h2);
			cmd(e[35:32], e[23:16], 13'h0);
			rc(crs_pkg::ADR_SUM, {24'h0, e[15:8]});
			rc(crs_pkg::ADR_FLAG, {24'h0, e[7:0]});
		end
	endtask : t_alu
	task t_call;
		cmd(crs_pkg::OP_RSP, 8'h0, 13'h0);
		cmd(crs_pkg::OP_CALL, 8'h0, 13'h0123);
		rc(crs_pkg::ADR_PUSH, 32'h7D);
		rc(crs_pkg::ADR_FETCH, 32'h123);
		cmd(crs_pkg::OP_PULL, 8'h0, 13'h0);
		rc(crs_pkg::ADR_PULLED, 32'h1A);
		cmd(crs_pkg::OP_PULL, 8'h0, 13'h0);
		rc(crs_pkg::ADR_PULLED, 32'hBC);
		cmd(crs_pkg::OP_CALL, 8'h0, 13'h0777);
		cmd(crs_pkg::OP_RTS, 8'h0, 13'h0);
		rc(crs_pkg::ADR_FETCH, 32'h123);
		rc(crs_pkg::ADR_PUSH, 32'h7F);
	endtask : t_call
	task t_wrap;
		cmd(crs_pkg::OP_RSP, 8'h0, 13'h0);
		for (int i = 0; i < 64; i++) begin
			cmd(crs_pkg::OP_PUSH, 8'(i), 13'h0);
		end
		rc(crs_pkg::ADR_PUSH, 32'h7F);
		cmd(crs_pkg::OP_PUSH, 8'hEE, 13'h0);
		rc(crs_pkg::ADR_PUSH, 32'h7E);
		cmd(crs_pkg::OP_PULL, 8'h0, 13'h0);
		rc(crs_pkg::ADR_PULLED, 32'hEE);
	endtask : t_wrap
	task t_swi;
		wr(crs_pkg::ADR_FLAG, 32'h0);
		wr(crs_pkg::ADR_SUM, 32'h11);
		wr(crs_pkg::ADR_OFFSET, 32'h22);
		wr(crs_pkg::ADR_FETCH, 32'h0456);
		cmd(crs_pkg::OP_SWI, 8'h0, 13'h0);
		rc(crs_pkg::ADR_PUSH, 32'h7A);
		rc(crs_pkg::ADR_FLAG, 32'h08);
		chk({19'h0, bus_addr}, 32'h1FFC);
		wr(crs_pkg::ADR_SUM, 32'h99);
		wr(crs_pkg::ADR_OFFSET, 32'h0);
		cmd(crs_pkg::OP_RTI, 8'h0, 13'h0);
		rc(crs_pkg::ADR_SUM, 32'h11);
		rc(crs_pkg::ADR_OFFSET, 32'h22);
		rc(crs_pkg::ADR_FETCH, 32'h0456);
		rc(crs_pkg::ADR_FLAG, 32'h0);
		rc(crs_pkg::ADR_PUSH, 32'h7F);
	endtask : t_swi
	task t_irq;
		wr(crs_pkg::ADR_FLAG, 32'h08);
		ext_go <= 1'b1;
		tmr_go <= 1'b1;
		@(posedge aclk);
		ext_go <= 1'b0;
		tmr_go <= 1'b0;
		repeat (8) @(posedge aclk);
		rc(crs_pkg::ADR_PEND, 32'h7);
		rc(crs_pkg::ADR_PUSH, 32'h7F);
		wr(crs_pkg::ADR_FLAG, 32'h0);
		idle();
		rc(crs_pkg::ADR_PUSH, 32'h7A);
		chk({19'h0, bus_addr}, 32'h1FFA);
		rc(crs_pkg::ADR_PEND, 32'h6);
		rc(crs_pkg::ADR_FLAG, 32'h08);
		wr(crs_pkg::ADR_FLAG, 32'h0);
		idle();
		rc(crs_pkg::ADR_PUSH, 32'h75);
		chk({19'h0, bus_addr}, 32'h1FF8);
		rc(crs_pkg::ADR_PEND, 32'h4);
	endtask : t_irq
	task t_pin;
		wr(crs_pkg::ADR_SUM, 32'h5A);
		wr(crs_pkg::ADR_FLAG, 32'h0);
		cmd(crs_pkg::OP_PUSH, 8'h1, 13'h0);
		rst_go <= 1'b1;
		@(posedge aclk);
		rst_go <= 1'b0;
		repeat (6) @(posedge aclk);
		@(negedge aclk);
		chk({31'h0, core_in_reset}, 32'h1);
		repeat (12) @(posedge aclk);
		rc(crs_pkg::ADR_PUSH, 32'h7F);
		rd(crs_pkg::ADR_FLAG);
		chk(d & 32'h8, 32'h8);
		rc(crs_pkg::ADR_SUM, 32'h5A);
		rc(crs_pkg::ADR_PEND, 32'h4);
	endtask : t_pin
	task summarize;
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rc(crs_pkg::ADR_PUSH, 32'h7F);
		rd(crs_pkg::ADR_FLAG);
		chk(d & 32'h8, 32'h8);
		chk({19'h0, bus_addr}, 32'h1FFE);
		t_regs();
		t_alu();
		t_call();
		t_wrap();
		t_swi();
		t_irq();
		t_pin();
		summarize();
	end
endmodule : tb_cpu_register_stack_state
